// [rtl/actp_params.svh]
// Constants of the audio clock tree: offsets, fields, resets and timing
`ifndef ACTP_PARAMS_SVH
`define ACTP_PARAMS_SVH

// =====================================================================
// Control port
`define ACTP_I2C_ADDR          7'h18
`define ACTP_PAGE_ZERO         8'h00

// =====================================================================
// Register offsets, page 0
`define ACTP_REG_PAGE_SELECT   8'h00
`define ACTP_REG_SOFT_RESET    8'h01
`define ACTP_REG_ROOT_SEL      8'h04
`define ACTP_REG_PLL_PR        8'h05
`define ACTP_REG_PLL_J         8'h06
`define ACTP_REG_PLL_DHI       8'h07
`define ACTP_REG_PLL_DLO       8'h08
`define ACTP_REG_FIRST_DIV     8'h0B
`define ACTP_REG_SECOND_DIV    8'h0C
`define ACTP_REG_OSR_HI        8'h0D
`define ACTP_REG_OSR_LO        8'h0E
`define ACTP_REG_GP_SRC        8'h19
`define ACTP_REG_GP_DIV        8'h1A
`define ACTP_REG_IFACE_CTRL    8'h1B
`define ACTP_REG_BCLK_SRC      8'h1D
`define ACTP_REG_BCLK_DIV      8'h1E
`define ACTP_REG_DAC_STATUS    8'h25
`define ACTP_REG_DAC_POWER     8'h3F

// =====================================================================
// Field positions
`define ACTP_BIT_DIV_ENABLE    7
`define ACTP_BIT_BCLK_DRIVE    3
`define ACTP_BIT_DAC_LEFT_PWR  7
`define ACTP_BIT_DAC_RIGHT_PWR 6
`define ACTP_BIT_STAT_LEFT     7
`define ACTP_BIT_STAT_RIGHT    3

// =====================================================================
// Reset values
`define ACTP_RST_PLL_PR        8'h11
`define ACTP_RST_PLL_J         8'h04
`define ACTP_RST_DIV           8'h01
`define ACTP_RST_OSR_HI        8'h00
`define ACTP_RST_OSR_LO        8'h80
`define ACTP_RST_ZERO          8'h00

// =====================================================================
// Timing
`define ACTP_CLK_PERIOD_NS     10
`define ACTP_PLL_SETTLE_MS     10
`define ACTP_PLL_SETTLE_CYCLES ((`ACTP_PLL_SETTLE_MS * 1000000) / `ACTP_CLK_PERIOD_NS)
`define ACTP_FRAC_SCALE        14'h2710
`define ACTP_SHUTDOWN_TICKS    8'h40

`endif

// [rtl/actp_pkg.sv]
// Types shared by the audio clock tree modules
package actp_pkg;

   typedef enum logic [2:0] {
      ACTP_I2C_IDLE  = 3'b000,
      ACTP_I2C_ADDR  = 3'b001,
      ACTP_I2C_ACK   = 3'b010,
      ACTP_I2C_WRITE = 3'b011,
      ACTP_I2C_READ  = 3'b100,
      ACTP_I2C_MACK  = 3'b101
   } actp_i2c_state_t;

endpackage

// [rtl/actp_clk_div.sv]
// Enable-gated divider of a tick stream, with pulse and square outputs
`timescale 1ns/100ps
module actp_clk_div #(
   parameter int W = 7
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic         en,
   input  wire logic         tick_in,
   input  wire logic [W-1:0] div_val,
   output logic              tick_out,
   output logic              level_out
);

   // A zero field stands for the largest count
   function automatic logic [W:0] span(input logic [W-1:0] v);
      span = (v == '0) ? {1'b1, {W{1'b0}}} : {1'b0, v};
   endfunction

   logic [W:0] count;
   wire  [W:0] n_val      = span(div_val);
   wire  [W:0] half       = (n_val + {{W{1'b0}}, 1'b1}) >> 1;
   wire        wrap       = (count >= n_val - {{W{1'b0}}, 1'b1});
   wire  [W:0] next_count = wrap ? '0 : count + {{W{1'b0}}, 1'b1};

   // Disabled: no edges, and restart from phase zero [R22]
   always_ff @(posedge sys_clk) begin
      if (srst || !en) begin
         count     <= '0;
         tick_out  <= 1'b0;
         level_out <= 1'b0;
      end else if (tick_in) begin
         count     <= next_count;
         tick_out  <= wrap;
         level_out <= (next_count < half);
      end else begin
         tick_out  <= 1'b0;
      end
   end

endmodule

// [rtl/actp_i2c_slave.sv]
// Register access port: I2C target with register pointer and auto-increment
`timescale 1ns/100ps
`include "actp_params.svh"
module actp_i2c_slave (
   input  wire logic       sys_clk,
   input  wire logic       srst,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_oe,
   output logic            wr_pulse,
   output logic [7:0]      wr_addr,
   output logic [7:0]      wr_data,
   output logic [7:0]      rd_addr,
   input  wire logic [7:0] rd_data
);

   // =====================================================================
   // Pin synchronisers
   logic [1:0] scl_s1, scl_s2;
   logic       scl_prev, sda_prev;
   always_ff @(posedge sys_clk) begin
      scl_s1   <= {scl_s1[0], scl_in};
      scl_s2   <= {scl_s2[0], sda_in};
      scl_prev <= scl_s1[1];
      sda_prev <= scl_s2[1];
   end
   wire scl      = scl_s1[1];
   wire sda      = scl_s2[1];
   wire scl_rise = scl & ~scl_prev;
   wire scl_fall = ~scl & scl_prev;
   wire start_c  = scl & scl_prev & sda_prev & ~sda;
   wire stop_c   = scl & scl_prev & ~sda_prev & sda;

   // =====================================================================
   // Byte engine
   actp_pkg::actp_i2c_state_t st;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic       is_read;
   logic       need_ptr;
   wire        addr_hit = (shreg[7:1] == `ACTP_I2C_ADDR);

   always_ff @(posedge sys_clk) begin
      wr_pulse <= 1'b0;
      if (srst || stop_c) begin
         st     <= actp_pkg::ACTP_I2C_IDLE;
         sda_oe <= 1'b0;
         if (srst) begin
            bitcnt   <= 4'h0;
            shreg    <= 8'h00;
            is_read  <= 1'b0;
            need_ptr <= 1'b0;
            rd_addr  <= 8'h00;
            wr_addr  <= 8'h00;
            wr_data  <= 8'h00;
         end
      end else if (start_c) begin
         st     <= actp_pkg::ACTP_I2C_ADDR;
         bitcnt <= 4'h0;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         case (st)
            actp_pkg::ACTP_I2C_ADDR, actp_pkg::ACTP_I2C_WRITE: begin
               shreg  <= {shreg[6:0], sda};
               bitcnt <= bitcnt + 4'h1;
            end
            actp_pkg::ACTP_I2C_READ: bitcnt <= bitcnt + 4'h1;
            actp_pkg::ACTP_I2C_MACK: if (sda) st <= actp_pkg::ACTP_I2C_IDLE;
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st)
            actp_pkg::ACTP_I2C_ADDR: if (bitcnt == 4'h8) begin
               // Only our own address is acknowledged [R19]
               st <= addr_hit ? actp_pkg::ACTP_I2C_ACK : actp_pkg::ACTP_I2C_IDLE;
               sda_oe   <= addr_hit;
               is_read  <= shreg[0];
               need_ptr <= ~shreg[0];
            end
            actp_pkg::ACTP_I2C_WRITE: if (bitcnt == 4'h8) begin
               st     <= actp_pkg::ACTP_I2C_ACK;
               sda_oe <= 1'b1;
               if (need_ptr) begin
                  rd_addr  <= shreg; // Register byte first, then data [R19]
                  need_ptr <= 1'b0;
               end else begin
                  wr_pulse <= 1'b1;
                  wr_addr  <= rd_addr;
                  wr_data  <= shreg;
                  rd_addr  <= rd_addr + 8'h01;
               end
            end
            actp_pkg::ACTP_I2C_ACK, actp_pkg::ACTP_I2C_MACK: begin
               bitcnt <= 4'h0;
               if (is_read) begin
                  st      <= actp_pkg::ACTP_I2C_READ;
                  shreg   <= rd_data;
                  sda_oe  <= ~rd_data[7];
                  rd_addr <= rd_addr + 8'h01;
               end else begin
                  st     <= actp_pkg::ACTP_I2C_WRITE;
                  sda_oe <= 1'b0;
               end
            end
            actp_pkg::ACTP_I2C_READ: if (bitcnt == 4'h8) begin
               st     <= actp_pkg::ACTP_I2C_MACK;
               sda_oe <= 1'b0;
            end else begin
               shreg  <= {shreg[6:0], 1'b0};
               sda_oe <= ~shreg[6];
            end
            default: ;
         endcase
      end
   end

endmodule

// [rtl/actp_top.sv]
// Audio clock tree: root select, fractional PLL model, cascaded dividers
//
// Overview of operation
// [R1] Root clock from master, bit, pin or PLL
// [R2] Modulator is root over both dividers; rate over ratio
// [R3] Divider fields in 11, 12; ratio in 13/14
// [R4] Host enables both dividers before DAC power-up
// [R5] Shutdown flags; host disables second then first
// [R6] Host disables parents only after children
// [R7] Driven bit clock divides source by 1..128
// [R8] Bit-clock source: processing or modulator clock
// [R9] General pin clock: selected source over 1..128
// [R10] PLL output is input times R, J.D over P
// [R11] Register 5: enable, P and R, default one
// [R12] J field 1..63, default four
// [R13] D fraction 14 bits split high and low
// [R14] Fraction applies only after low-byte write
// [R15] Host keeps PLL input over P in range
// [R16] Host keeps root, processing, modulator clocks bounded
// [R17] Host limits general clock source frequency
// [R18] Software reset also switches PLL off
// [R19] Writes at address 0x30: register, then data
// [R20] PLL output used only after settling time
// [R21] Host powers PLL first, down last
// [R22] Disabled dividers silent, restart from known phase
`timescale 1ns/100ps
`include "actp_params.svh"
module actp_top #(
   parameter int unsigned PLL_SETTLE_CYCLES = `ACTP_PLL_SETTLE_CYCLES
) (
   input  wire logic sys_clk,
   input  wire logic srst,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe,
   input  wire logic mclk_in,
   input  wire logic bclk_in,
   output logic      bclk_out,
   output logic      bclk_oe,
   input  wire logic general_pin_one_in,
   output logic      general_pin_one_out,
   output logic      general_pin_one_oe,
   output logic      modulator_clock_tick,
   output logic      sample_rate_tick,
   output logic      pll_locked
);

   // =====================================================================
   // Register port
   logic       wr_pulse;
   logic [7:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_addr;
   wire  [7:0] rd_data;

   actp_i2c_slave u_i2c (
      .sys_clk  (sys_clk),
      .srst     (srst),
      .scl_in   (scl_in),
      .sda_in   (sda_in),
      .sda_oe   (sda_oe),
      .wr_pulse (wr_pulse),
      .wr_addr  (wr_addr),
      .wr_data  (wr_data),
      .rd_addr  (rd_addr),
      .rd_data  (rd_data)
   );

   // =====================================================================
   // Register file, page 0
   logic [7:0] page_select;
   logic [7:0] root_clock_select;
   logic [7:0] pll_enable_prediv_mult;
   logic [7:0] pll_integer_mult;
   logic [7:0] pll_fraction_high;
   logic [7:0] pll_fraction_low;
   logic [7:0] first_divider_ctrl;
   logic [7:0] second_divider_ctrl;
   logic [7:0] oversample_ratio_high;
   logic [7:0] oversample_ratio_low;
   logic [7:0] gp_clock_source_select;
   logic [7:0] gp_clock_divider;
   logic [7:0] iface_ctrl;
   logic [7:0] bitclock_source_select;
   logic [7:0] bitclock_divider;
   logic [7:0] dac_power_ctrl;
   logic [13:0] pll_fraction;
   logic [1:0]  dac_powered;
   logic       soft_rst;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] target,
                                input logic [7:0] page);
      hit = (a == target) && (page == `ACTP_PAGE_ZERO);
   endfunction

   wire p0 = wr_pulse;
   wire wr_page  = p0 && (wr_addr == `ACTP_REG_PAGE_SELECT);
   wire wr_reset = p0 && hit(wr_addr, `ACTP_REG_SOFT_RESET, page_select) && wr_data[0];
   wire wr_dlo   = p0 && hit(wr_addr, `ACTP_REG_PLL_DLO, page_select);
   wire reg_rst  = srst || soft_rst;

   // Software reset takes effect one cycle after the write [R18]
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= wr_reset;
      end
   end

   // Register writes; the reset also clears the PLL enable [R18]
   always_ff @(posedge sys_clk) begin
      if (reg_rst) begin
         page_select            <= `ACTP_RST_ZERO;
         root_clock_select      <= `ACTP_RST_ZERO;
         pll_enable_prediv_mult <= `ACTP_RST_PLL_PR; // [R11]
         pll_integer_mult       <= `ACTP_RST_PLL_J;  // [R12]
         pll_fraction_high      <= `ACTP_RST_ZERO;
         pll_fraction_low       <= `ACTP_RST_ZERO;
         first_divider_ctrl     <= `ACTP_RST_DIV;
         second_divider_ctrl    <= `ACTP_RST_DIV;
         oversample_ratio_high  <= `ACTP_RST_OSR_HI;
         oversample_ratio_low   <= `ACTP_RST_OSR_LO;
         gp_clock_source_select <= `ACTP_RST_ZERO;
         gp_clock_divider       <= `ACTP_RST_DIV;
         iface_ctrl             <= `ACTP_RST_ZERO;
         bitclock_source_select <= `ACTP_RST_ZERO;
         bitclock_divider       <= `ACTP_RST_DIV;
         dac_power_ctrl         <= `ACTP_RST_ZERO;
         pll_fraction           <= 14'h0000; // [R13]
      end else if (p0) begin
         if (wr_page) page_select <= wr_data; // [R19]
         if (hit(wr_addr, `ACTP_REG_ROOT_SEL, page_select)) root_clock_select <= wr_data;
         if (hit(wr_addr, `ACTP_REG_PLL_PR, page_select)) pll_enable_prediv_mult <= wr_data;
         if (hit(wr_addr, `ACTP_REG_PLL_J, page_select)) pll_integer_mult <= wr_data & 8'h3F;
         if (hit(wr_addr, `ACTP_REG_PLL_DHI, page_select)) pll_fraction_high <= wr_data & 8'h3F;
         if (wr_dlo) begin
            pll_fraction_low <= wr_data;
            pll_fraction     <= {pll_fraction_high[5:0], wr_data}; // [R14] [R13]
         end
         if (hit(wr_addr, `ACTP_REG_FIRST_DIV, page_select)) first_divider_ctrl <= wr_data;
         if (hit(wr_addr, `ACTP_REG_SECOND_DIV, page_select)) second_divider_ctrl <= wr_data;
         if (hit(wr_addr, `ACTP_REG_OSR_HI, page_select)) oversample_ratio_high <= wr_data & 8'h03;
         if (hit(wr_addr, `ACTP_REG_OSR_LO, page_select)) oversample_ratio_low <= wr_data;
         if (hit(wr_addr, `ACTP_REG_GP_SRC, page_select)) gp_clock_source_select <= wr_data & 8'h07;
         if (hit(wr_addr, `ACTP_REG_GP_DIV, page_select)) gp_clock_divider <= wr_data;
         if (hit(wr_addr, `ACTP_REG_IFACE_CTRL, page_select)) iface_ctrl <= wr_data;
         if (hit(wr_addr, `ACTP_REG_BCLK_SRC, page_select)) bitclock_source_select <= wr_data;
         if (hit(wr_addr, `ACTP_REG_BCLK_DIV, page_select)) bitclock_divider <= wr_data;
         if (hit(wr_addr, `ACTP_REG_DAC_POWER, page_select)) dac_power_ctrl <= wr_data;
      end
   end

   // Status register: live shutdown state of each channel [R5]
   wire [7:0] dac_power_status = {dac_powered[0], 3'b000, dac_powered[1], 3'b000};

   function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] page);
      reg_read = 8'h00;
      if (a == `ACTP_REG_PAGE_SELECT) reg_read = page_select;
      else if (page == `ACTP_PAGE_ZERO) begin
         case (a)
            `ACTP_REG_ROOT_SEL:    reg_read = root_clock_select;
            `ACTP_REG_PLL_PR:      reg_read = pll_enable_prediv_mult;
            `ACTP_REG_PLL_J:       reg_read = pll_integer_mult;
            `ACTP_REG_PLL_DHI:     reg_read = pll_fraction_high;
            `ACTP_REG_PLL_DLO:     reg_read = pll_fraction_low;
            `ACTP_REG_FIRST_DIV:   reg_read = first_divider_ctrl;
            `ACTP_REG_SECOND_DIV:  reg_read = second_divider_ctrl;
            `ACTP_REG_OSR_HI:      reg_read = oversample_ratio_high;
            `ACTP_REG_OSR_LO:      reg_read = oversample_ratio_low;
            `ACTP_REG_GP_SRC:      reg_read = gp_clock_source_select;
            `ACTP_REG_GP_DIV:      reg_read = gp_clock_divider;
            `ACTP_REG_IFACE_CTRL:  reg_read = iface_ctrl;
            `ACTP_REG_BCLK_SRC:    reg_read = bitclock_source_select;
            `ACTP_REG_BCLK_DIV:    reg_read = bitclock_divider;
            `ACTP_REG_DAC_STATUS:  reg_read = dac_power_status;
            `ACTP_REG_DAC_POWER:   reg_read = dac_power_ctrl;
            default:               reg_read = 8'h00;
         endcase
      end
   endfunction

   assign rd_data = reg_read(rd_addr, page_select);

   // =====================================================================
   // Clock pins, sampled as tick streams
   logic [2:0] pin_s1, pin_s2, pin_prev;
   always_ff @(posedge sys_clk) begin
      pin_s1   <= {general_pin_one_in, bclk_in, mclk_in};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
   end
   wire [2:0] pin_tick = pin_s2 & ~pin_prev;

   // =====================================================================
   // Fractional PLL model: credit-based tick multiplier
   // Output is capped at one tick per sys_clk; a real PLL is far faster
   wire        pll_en    = pll_enable_prediv_mult[7];
   wire [3:0]  p_val     = (pll_enable_prediv_mult[6:4] == 3'b000) ? 4'h8
                                                                  : {1'b0, pll_enable_prediv_mult[6:4]};
   wire [4:0]  r_val     = (pll_enable_prediv_mult[3:0] == 4'h0) ? 5'h10
                                                                 : {1'b0, pll_enable_prediv_mult[3:0]};
   wire [19:0] jd_val    = 20'(pll_integer_mult[5:0]) * 20'(`ACTP_FRAC_SCALE) + 20'(pll_fraction);
   wire [24:0] pll_step  = 25'(r_val) * 25'(jd_val);
   wire [16:0] pll_thr   = 17'(p_val) * 17'(`ACTP_FRAC_SCALE);
   wire        pll_src   = (root_clock_select[3:2] == 2'b00) ? pin_tick[0] :
                           (root_clock_select[3:2] == 2'b01) ? pin_tick[1] :
                           (root_clock_select[3:2] == 2'b10) ? pin_tick[2] : 1'b0;
   logic [27:0] pll_credit;
   logic [31:0] settle_cnt;
   logic        pll_tick;
   wire  [27:0] credit_add = (pll_src && !pll_credit[27]) ? 28'(pll_step) : 28'h0000000;
   wire         credit_ok  = (pll_credit >= 28'(pll_thr));

   // Multiply by R and J.D, divide by P [R10]
   always_ff @(posedge sys_clk) begin
      if (reg_rst || !pll_en) begin
         pll_credit <= 28'h0000000;
         pll_tick   <= 1'b0;
      end else begin
         pll_credit <= pll_credit + credit_add - (credit_ok ? 28'(pll_thr) : 28'h0000000);
         pll_tick   <= credit_ok && pll_locked;
      end
   end

   // Output held off until the settling time has passed [R20]
   always_ff @(posedge sys_clk) begin
      if (reg_rst || !pll_en) begin
         settle_cnt <= 32'h00000000;
         pll_locked <= 1'b0;
      end else if (!pll_locked) begin
         settle_cnt <= settle_cnt + 32'h00000001;
         pll_locked <= (settle_cnt >= PLL_SETTLE_CYCLES - 1);
      end
   end

   // =====================================================================
   // Root clock and cascaded dividers
   wire root_tick = (root_clock_select[1:0] == 2'b00) ? pin_tick[0] : // [R1]
                    (root_clock_select[1:0] == 2'b01) ? pin_tick[1] :
                    (root_clock_select[1:0] == 2'b10) ? pin_tick[2] : pll_tick;
   wire mac_tick;
   wire mod_tick;
   wire fs_tick;
   wire bclk_level;
   wire gp_level;
   wire div1_on = first_divider_ctrl[`ACTP_BIT_DIV_ENABLE];
   wire div2_on = second_divider_ctrl[`ACTP_BIT_DIV_ENABLE];

   // Modulator = root / (first x second); rate = modulator / ratio [R2] [R3]
   actp_clk_div #(.W(7)) u_first_divider (
      .sys_clk (sys_clk), .srst (reg_rst), .en (div1_on), .tick_in (root_tick),
      .div_val (first_divider_ctrl[6:0]), .tick_out (mac_tick), .level_out ()
   );
   actp_clk_div #(.W(7)) u_second_divider (
      .sys_clk (sys_clk), .srst (reg_rst), .en (div2_on), .tick_in (mac_tick),
      .div_val (second_divider_ctrl[6:0]), .tick_out (mod_tick), .level_out ()
   );
   actp_clk_div #(.W(10)) u_oversample_ratio (
      .sys_clk (sys_clk), .srst (reg_rst), .en (div1_on && div2_on), .tick_in (mod_tick),
      .div_val ({oversample_ratio_high[1:0], oversample_ratio_low}),
      .tick_out (fs_tick), .level_out ()
   );

   // Bit clock source: processing or modulator clock [R8]
   wire bclk_src = (bitclock_source_select[1:0] == 2'b00) ? mac_tick :
                   (bitclock_source_select[1:0] == 2'b01) ? mod_tick : 1'b0;
   actp_clk_div #(.W(7)) u_bitclock_divider ( // [R7]
      .sys_clk (sys_clk), .srst (reg_rst), .en (bitclock_divider[`ACTP_BIT_DIV_ENABLE]),
      .tick_in (bclk_src), .div_val (bitclock_divider[6:0]),
      .tick_out (), .level_out (bclk_level)
   );

   // General clock source multiplexer [R9]
   wire [7:0] gp_sources = {2'b00, mod_tick, mac_tick, pll_tick, 1'b0, pin_tick[1], pin_tick[0]};
   wire       gp_src     = gp_sources[gp_clock_source_select[2:0]];
   actp_clk_div #(.W(7)) u_gp_clock_divider (
      .sys_clk (sys_clk), .srst (reg_rst), .en (gp_clock_divider[`ACTP_BIT_DIV_ENABLE]),
      .tick_in (gp_src), .div_val (gp_clock_divider[6:0]),
      .tick_out (), .level_out (gp_level)
   );

   // =====================================================================
   // DAC channel power and shutdown sequence
   // Shutdown only advances on modulator ticks, so it stalls if the host
   // turns the dividers off early
   logic [7:0] shut_cnt [2];
   wire  [1:0] dac_req = {dac_power_ctrl[`ACTP_BIT_DAC_RIGHT_PWR],
                          dac_power_ctrl[`ACTP_BIT_DAC_LEFT_PWR]};

   always_ff @(posedge sys_clk) begin
      for (int i = 0; i < 2; i++) begin
         if (reg_rst) begin
            dac_powered[i] <= 1'b0;
            shut_cnt[i]    <= 8'h00;
         end else if (dac_req[i]) begin
            shut_cnt[i] <= 8'h00;
            if (mod_tick) dac_powered[i] <= 1'b1;
         end else if (dac_powered[i] && mod_tick) begin
            shut_cnt[i] <= shut_cnt[i] + 8'h01; // [R5]
            if (shut_cnt[i] == `ACTP_SHUTDOWN_TICKS - 8'h01) dac_powered[i] <= 1'b0;
         end
      end
   end

   // =====================================================================
   // Registered outputs
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sda_out              <= 1'b0;
         bclk_out             <= 1'b0;
         bclk_oe              <= 1'b0;
         general_pin_one_out  <= 1'b0;
         general_pin_one_oe   <= 1'b0;
         modulator_clock_tick <= 1'b0;
         sample_rate_tick     <= 1'b0;
      end else begin
         sda_out              <= 1'b0;
         bclk_out             <= bclk_level;
         bclk_oe              <= iface_ctrl[`ACTP_BIT_BCLK_DRIVE]; // [R7]
         general_pin_one_out  <= gp_level;
         general_pin_one_oe   <= gp_clock_divider[`ACTP_BIT_DIV_ENABLE]; // [R9]
         modulator_clock_tick <= mod_tick;
         sample_rate_tick     <= fs_tick;
      end
   end

endmodule

// [verification/actp_host_model.sv]
// Host side: I2C controller writing the control registers
`timescale 1ns/100ps
module actp_host_model (
   input  wire logic sys_clk,
   input  wire logic sda_oe,
   output logic      scl = 1'b1,
   output logic      sda = 1'b1,
   output int        nacks = 0
);
   // =========================================
   // Bus phases, eight system clocks each
   task automatic step(input logic s, input logic d);
      scl <= s;
      sda <= d;
      repeat (8) @(posedge sys_clk);
   endtask

   // SDA changes while SCL is low except for start and stop; released for the ACK slot
   task automatic wr(input logic [7:0] r, input logic [7:0] d);
      logic [23:0] f;
      f = {8'h30, r, d};
      step(1, 1);
      step(1, 0);
      for (int i = 23; i >= 0; i--) begin
         step(0, f[i]);
         step(1, f[i]);
         step(0, f[i]);
         if (i % 8 == 0) begin
            step(0, 1);
            step(1, 1);
            if (sda_oe !== 1'b1) nacks++;
            step(0, 1);
         end
      end
      step(0, 0);
      step(1, 0);
      step(1, 1);
   endtask
endmodule

// [verification/actp_top_monitor.sv]
// Checker of the clock tree ports
`timescale 1ns/100ps
module actp_top_monitor (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic bclk_oe,
   input wire logic general_pin_one_oe,
   input wire logic modulator_clock_tick,
   input wire logic sample_rate_tick,
   input wire logic pll_locked
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_pulse; modulator_clock_tick ##1 !modulator_clock_tick; endsequence
   property p_quiet; disable iff (1'b0) srst |=> !pll_locked && !bclk_oe; endproperty
   property p_sda; sda_out == 1'b0; endproperty
   property p_mod; modulator_clock_tick |-> s_pulse; endproperty
   property p_fs; sample_rate_tick |=> !sample_rate_tick [*2]; endproperty
   property p_fs_mod; sample_rate_tick |-> $past(modulator_clock_tick, 2) ||
      $past(modulator_clock_tick) || modulator_clock_tick; endproperty
   property p_lock; $rose(pll_locked) |-> !$past(srst, 20); endproperty
   property p_boe; $rose(bclk_oe) |-> ##[0:8] sda_oe; endproperty
   property p_goe; $rose(general_pin_one_oe) |-> ##[0:8] sda_oe; endproperty
   a_quiet: assert property (p_quiet) else $error("active after reset");
   a_sda: assert property (p_sda) else $error("sda data high");
   a_mod: assert property (p_mod) else $error("long mod tick");
   a_fs: assert property (p_fs) else $error("long rate tick");
   a_fs_mod: assert property (p_fs_mod) else $error("rate tick alone");
   a_lock: assert property (p_lock) else $error("early lock");
   a_boe: assert property (p_boe) else $error("bclk drive unasked");
   a_goe: assert property (p_goe) else $error("pin drive unasked");
endmodule
bind actp_top actp_top_monitor u_mon (.sys_clk, .srst, .sda_out, .sda_oe, .bclk_oe,
   .general_pin_one_oe, .modulator_clock_tick, .sample_rate_tick, .pll_locked);

// [verification/test_audio_clock_tree_and_pll.sv]
// Self-checking bench of the audio clock tree
`timescale 1ns/100ps
module test_audio_clock_tree_and_pll;
   logic sys_clk = 0, srst = 1, mclk = 0, scl, sda_h, sda_oe, sda_out, bclk_out, bclk_oe;
   logic general_pin_one_out, general_pin_one_oe, modulator_clock_tick, sample_rate_tick;
   logic pll_locked;
   int err_count = 0, n_compared = 0, nacks, cyc = 0, nm, ns, nb, ng;
   always #5 sys_clk = ~sys_clk;
   // Master clock at one eighth of the system rate, slow enough to be sampled
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) mclk <= ~mclk;
      if (cyc == 40000) begin
         err_count++;
         conclude();
      end
   end
   actp_host_model host (.sys_clk, .sda_oe, .scl, .sda(sda_h), .nacks);
   actp_top #(.PLL_SETTLE_CYCLES(20)) uut (.sys_clk, .srst, .scl_in(scl),
      .sda_in(sda_h & ~sda_oe), .sda_out, .sda_oe, .mclk_in(mclk), .bclk_in(1'b0),
      .bclk_out, .bclk_oe, .general_pin_one_in(1'b0), .general_pin_one_out,
      .general_pin_one_oe, .modulator_clock_tick, .sample_rate_tick, .pll_locked);
   task automatic chk(string s, logic [31:0] e, logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("wrong value %s expected %0d seen %0d", s, e, g);
      end
   endtask
   // Window of 512 cycles is a whole number of every output period used here
   task automatic cnt();
      logic pb, pg;
      {nm, ns, nb, ng} = '0;
      pb = bclk_out;
      pg = general_pin_one_out;
      repeat (512) begin
         @(posedge sys_clk);
         nm += modulator_clock_tick;
         ns += sample_rate_tick;
         nb += bclk_out & !pb;
         ng += general_pin_one_out & !pg;
         pb = bclk_out;
         pg = general_pin_one_out;
      end
   endtask
   task automatic conclude();
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 0;
      repeat (4) @(posedge sys_clk);
      host.wr(8'h04, 8'h00);
      host.wr(8'h0B, 8'h82);
      host.wr(8'h0C, 8'h82);
      host.wr(8'h0D, 8'h00);
      host.wr(8'h0E, 8'h04);
      host.wr(8'h1B, 8'h08);
      host.wr(8'h1D, 8'h01);
      host.wr(8'h1E, 8'h82);
      host.wr(8'h19, 8'h00);
      host.wr(8'h1A, 8'h84);
      cnt();
      chk("mod ticks", 16, nm);
      chk("rate ticks", 4, ns);
      chk("bclk drive", 1, bclk_oe);
      chk("bclk rises", 8, nb);
      chk("pin rises", 16, ng);
      chk("pin drive", 1, general_pin_one_oe);
      host.wr(8'h0C, 8'h02);
      host.wr(8'h0B, 8'h02);
      cnt();
      chk("gated mod", 0, nm);
      host.wr(8'h05, 8'h91);
      host.wr(8'h04, 8'h03);
      host.wr(8'h0B, 8'h82);
      host.wr(8'h0C, 8'h82);
      chk("locked", 1, pll_locked);
      cnt();
      chk("pll mod", 64, nm);
      host.wr(8'h07, 8'h13);
      cnt();
      chk("half fraction", 64, nm);
      host.wr(8'h08, 8'h88);
      cnt();
      chk("fraction mod", 72, nm);
      host.wr(8'h01, 8'h01);
      chk("reset lock", 0, pll_locked);
      chk("reset drive", 0, bclk_oe);
      chk("acks", 0, nacks);
      conclude();
   end
endmodule
